//--- src/tdct_top.sv
// Behaviour
// - Stop command halts the counter and drives output to given level.
// - Reading the live count never disturbs counting.
// - Binary counts span the full 16-bit range; decimal counts 0 to 9999.
// - Per-counter choice of 16-bit binary or four-decade BCD counting.
// - Writing a new count loads it and keeps the programmed mode.
// - Terminal toggle mode: output goes low when mode is programmed.
// - Toggle and software strobe modes count only while gate is high.
// - Toggle mode: terminal count drives output high until the mode is programmed again.
// - Single pulse mode: output falls on next rising gate edge.
// - Single pulse mode: output returns high at terminal count.
// - Periodic pulse mode: output low for one input clock period.
// - Programmed count sets pulse-to-pulse interval in input clocks.
// - Half duty mode: output high half the count, low the other half.
// - Software strobe mode: output starts high once programmed.
// - Software strobe: one-period low pulse at terminal count.
// - Gate started strobe: like software strobe, started by gate edge.
`include "tdct_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tdct_top #(
  parameter int unsigned NUM_CNT = 3
) (
  // Clock, reset, enable
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_ce,
  // Register port
  input  wire tdct_pkg::tdct_bus_req_t i_bus,
  output logic [31:0]                o_rdata,
  // Counter pins
  input  wire logic [NUM_CNT-1:0]    i_cnt_clk,
  input  wire logic [NUM_CNT-1:0]    i_cnt_gate,
  output logic [NUM_CNT-1:0]         o_cnt_out
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  // The counter select field is two bits wide, so four is the most.
  if (NUM_CNT < 1 || NUM_CNT > 4)
  begin : g_bad_num
    $error("tdct_top: NUM_CNT must lie between 1 and 4");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    tdct_pkg::tdct_chan_t [NUM_CNT-1:0] chan;
    logic [31:0]                        rdata;
  } tdct_state_t;

  localparam tdct_pkg::tdct_chan_t CHAN_RST = '{
    mode:               tdct_pkg::terminal_toggle_mode,
    count_radix_select: tdct_pkg::pure_binary_radix,
    count:              `TDCT_RST_COUNT,
    reload:             `TDCT_RST_COUNT,
    out:                `TDCT_RST_OUT,
    run:                1'b0,
    halted:             `TDCT_RST_HALT,
    strobe_low:         1'b0,
    clk_sync:           2'b00,
    clk_prev:           1'b0,
    gate_sync:          2'b00,
    gate_prev:          1'b0
  };

  tdct_state_t st;
  tdct_state_t next_st;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // One step down; 0 wraps to the top of the range in either radix
  function automatic logic [15:0] dec_count(input logic [15:0] v,
                                            input tdct_pkg::tdct_radix_t r);
    logic [15:0] res;
    logic        borrow;
    res    = v;
    borrow = 1'b1;
    if (r == tdct_pkg::pure_binary_radix)
    begin
      res = v - 16'h0001;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (borrow)
        begin
          if (v[4*i +: 4] == 4'h0)
          begin
            res[4*i +: 4] = 4'h9;
          end
          else
          begin
            res[4*i +: 4] = v[4*i +: 4] - 4'h1;
            borrow        = 1'b0;
          end
        end
      end
    end
    return res;
  endfunction

  // Half of a reload value, rounded down; 0 stands for the full range
  function automatic logic [15:0] half_count(input logic [15:0] v,
                                             input tdct_pkg::tdct_radix_t r);
    logic [15:0] res;
    logic [4:0]  dig;
    logic        rem;
    res = 16'h0000;
    dig = 5'h00;
    rem = 1'b0;
    if (v == 16'h0000)
    begin
      res = (r == tdct_pkg::pure_binary_radix) ? `TDCT_BIN_FULL_HALF : `TDCT_BCD_FULL_HALF;
    end
    else if (r == tdct_pkg::pure_binary_radix)
    begin
      res = {1'b0, v[15:1]};
    end
    else
    begin
      // Decimal halving digit by digit, an odd digit carries ten downward
      for (int i = 3; i >= 0; i--)
      begin
        dig           = {1'b0, v[4*i +: 4]} + (rem ? 5'd10 : 5'd0);
        res[4*i +: 4] = dig[4:1];
        rem           = dig[0];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    logic                  tick;
    logic                  grise;
    logic                  glev;
    logic [15:0]           stepped;
    logic [1:0]            sel_reg;
    logic [1:0]            sel_cnt;
    tdct_pkg::tdct_chan_t  c;
    tick    = 1'b0;
    grise   = 1'b0;
    glev    = 1'b0;
    stepped = 16'h0000;
    sel_reg = i_bus.addr[`TDCT_ADDR_REG_MSB:`TDCT_ADDR_REG_LSB];
    sel_cnt = i_bus.addr[`TDCT_ADDR_CNT_MSB:`TDCT_ADDR_CNT_LSB];
    c       = CHAN_RST;
    next_st = st;
    next_st.rdata = `TDCT_RST_RDATA;

    for (int k = 0; k < NUM_CNT; k++)
    begin
      c = st.chan[k];
      // Pins cross into this clock through two flops; edges use only stage two
      next_st.chan[k].clk_sync  = {st.chan[k].clk_sync[0], i_cnt_clk[k]};
      next_st.chan[k].clk_prev  = st.chan[k].clk_sync[1];
      next_st.chan[k].gate_sync = {st.chan[k].gate_sync[0], i_cnt_gate[k]};
      next_st.chan[k].gate_prev = st.chan[k].gate_sync[1];
      tick    = st.chan[k].clk_sync[1] & ~st.chan[k].clk_prev;
      grise   = st.chan[k].gate_sync[1] & ~st.chan[k].gate_prev;
      glev    = st.chan[k].gate_sync[1];
      stepped = dec_count(c.count, c.count_radix_select);

      // Counting, frozen entirely while the counter is stopped
      if (!c.halted)
      begin
        case (c.mode)
          tdct_pkg::terminal_toggle_mode:
          begin
            if (tick && glev)
            begin
              next_st.chan[k].count = stepped;
              if (c.count == `TDCT_TERMINAL)
              begin
                next_st.chan[k].out = 1'b1;
              end
            end
          end
          tdct_pkg::gated_single_pulse_mode:
          begin
            // A new gate edge restarts the pulse, so it is retriggerable
            if (grise)
            begin
              next_st.chan[k].out   = 1'b0;
              next_st.chan[k].count = c.reload;
              next_st.chan[k].run   = 1'b1;
            end
            else if (tick && c.run)
            begin
              next_st.chan[k].count = stepped;
              if (c.count == `TDCT_TERMINAL)
              begin
                next_st.chan[k].out = 1'b1;
                next_st.chan[k].run = 1'b0;
              end
            end
          end
          tdct_pkg::periodic_pulse_mode:
          begin
            if (!glev)
            begin
              next_st.chan[k].out = 1'b1;
            end
            else if (tick)
            begin
              if (c.count == `TDCT_TERMINAL)
              begin
                next_st.chan[k].out   = 1'b0;
                next_st.chan[k].count = c.reload;
              end
              else
              begin
                next_st.chan[k].out   = 1'b1;
                next_st.chan[k].count = stepped;
              end
            end
          end
          tdct_pkg::half_duty_wave_mode:
          begin
            // Odd counts give the extra period to the high phase
            if (tick && glev)
            begin
              if (c.count == `TDCT_TERMINAL)
              begin
                next_st.chan[k].out   = 1'b1;
                next_st.chan[k].count = c.reload;
              end
              else
              begin
                next_st.chan[k].count = stepped;
                if (stepped == half_count(c.reload, c.count_radix_select))
                begin
                  next_st.chan[k].out = 1'b0;
                end
              end
            end
          end
          tdct_pkg::software_strobe_mode,
          tdct_pkg::gate_started_strobe_mode:
          begin
            // The low pulse ends on the next input clock, gate or not
            if (tick && c.strobe_low)
            begin
              next_st.chan[k].out        = 1'b1;
              next_st.chan[k].strobe_low = 1'b0;
            end
            if (c.mode == tdct_pkg::gate_started_strobe_mode && grise)
            begin
              next_st.chan[k].count = c.reload;
              next_st.chan[k].run   = 1'b1;
            end
            else if (tick && c.run &&
                     (glev || c.mode == tdct_pkg::gate_started_strobe_mode))
            begin
              next_st.chan[k].count = stepped;
              if (c.count == `TDCT_TERMINAL)
              begin
                next_st.chan[k].out        = 1'b0;
                next_st.chan[k].strobe_low = 1'b1;
                next_st.chan[k].run        = 1'b0;
              end
            end
          end
          default:
          begin
            next_st.chan[k].run = 1'b0;
          end
        endcase
      end

      // Register writes take precedence over counting in the same cycle
      if (i_bus.wr && sel_cnt == 2'(k))
      begin
        if (sel_reg == `TDCT_REG_SETUP)
        begin
          // Unknown mode codes are ignored so a stray write cannot corrupt a channel
          if (i_bus.wdata[`TDCT_F_MODE_MSB:`TDCT_F_MODE_LSB] <= `TDCT_MODE_LAST)
          begin
            next_st.chan[k].mode = tdct_pkg::tdct_mode_t'(
              i_bus.wdata[`TDCT_F_MODE_MSB:`TDCT_F_MODE_LSB]);
            next_st.chan[k].count_radix_select = tdct_pkg::tdct_radix_t'(
              i_bus.wdata[`TDCT_F_RADIX]);
            next_st.chan[k].count      = i_bus.wdata[`TDCT_F_COUNT_MSB:`TDCT_F_COUNT_LSB];
            next_st.chan[k].reload     = i_bus.wdata[`TDCT_F_COUNT_MSB:`TDCT_F_COUNT_LSB];
            next_st.chan[k].halted     = 1'b0;
            next_st.chan[k].strobe_low = 1'b0;
            case (tdct_pkg::tdct_mode_t'(i_bus.wdata[`TDCT_F_MODE_MSB:`TDCT_F_MODE_LSB]))
              tdct_pkg::terminal_toggle_mode:
              begin
                next_st.chan[k].out = 1'b0;
                next_st.chan[k].run = 1'b1;
              end
              tdct_pkg::gated_single_pulse_mode,
              tdct_pkg::gate_started_strobe_mode:
              begin
                next_st.chan[k].out = 1'b1;
                next_st.chan[k].run = 1'b0;
              end
              tdct_pkg::software_strobe_mode:
              begin
                next_st.chan[k].out = 1'b1;
                next_st.chan[k].run = 1'b1;
              end
              default:
              begin
                next_st.chan[k].out = 1'b1;
                next_st.chan[k].run = 1'b1;
              end
            endcase
          end
        end
        else if (sel_reg == `TDCT_REG_RELOAD)
        begin
          // Mode, output and halt state are left exactly as they were
          next_st.chan[k].count  = i_bus.wdata[`TDCT_F_COUNT_MSB:`TDCT_F_COUNT_LSB];
          next_st.chan[k].reload = i_bus.wdata[`TDCT_F_COUNT_MSB:`TDCT_F_COUNT_LSB];
        end
        else if (sel_reg == `TDCT_REG_STOP)
        begin
          next_st.chan[k].halted     = 1'b1;
          next_st.chan[k].run        = 1'b0;
          next_st.chan[k].strobe_low = 1'b0;
          next_st.chan[k].out        = i_bus.wdata[`TDCT_F_LEVEL];
        end
      end

      // Reads only sample; nothing in the counter changes because of them
      if (i_bus.rd && sel_cnt == 2'(k))
      begin
        if (sel_reg == `TDCT_REG_SETUP)
        begin
          next_st.rdata[`TDCT_F_COUNT_MSB:`TDCT_F_COUNT_LSB] = c.reload;
          next_st.rdata[`TDCT_F_MODE_MSB:`TDCT_F_MODE_LSB]   = c.mode;
          next_st.rdata[`TDCT_F_RADIX] = c.count_radix_select;
          next_st.rdata[`TDCT_F_OUT]   = c.out;
          next_st.rdata[`TDCT_F_HALT]  = c.halted;
          next_st.rdata[`TDCT_F_RUN]   = c.run;
        end
        else if (sel_reg == `TDCT_REG_RELOAD)
        begin
          next_st.rdata[`TDCT_F_COUNT_MSB:`TDCT_F_COUNT_LSB] = c.reload;
        end
        else if (sel_reg == `TDCT_REG_LIVE)
        begin
          next_st.rdata[`TDCT_F_COUNT_MSB:`TDCT_F_COUNT_LSB] = c.count;
        end
        else
        begin
          next_st.rdata = `TDCT_RST_RDATA;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Clock enable low freezes everything, synchronisers included
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st <= '{chan: {NUM_CNT{CHAN_RST}}, rdata: `TDCT_RST_RDATA};
    end
    else if (i_ce)
    begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Read data is zero after every enabled clock that carries no read
  assign o_rdata = st.rdata;

  // Waveform pins come straight from the per-counter output flops
  always_comb
  begin
    o_cnt_out = '0;
    for (int k = 0; k < NUM_CNT; k++)
    begin
      o_cnt_out[k] = st.chan[k].out;
    end
  end

endmodule

`default_nettype wire

//--- src/tdct_map.svh
`ifndef TDCT_MAP_SVH
`define TDCT_MAP_SVH

// ------------------------------------------------------------
// Register offsets (word index inside one counter's slot)
// ------------------------------------------------------------
`define TDCT_REG_SETUP      2'h0
`define TDCT_REG_RELOAD     2'h1
`define TDCT_REG_LIVE       2'h2
`define TDCT_REG_STOP       2'h3

// ------------------------------------------------------------
// Address split: upper bits pick the counter, lower the register
// ------------------------------------------------------------
`define TDCT_ADDR_CNT_MSB   3
`define TDCT_ADDR_CNT_LSB   2
`define TDCT_ADDR_REG_MSB   1
`define TDCT_ADDR_REG_LSB   0

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TDCT_F_COUNT_MSB    15
`define TDCT_F_COUNT_LSB    0
`define TDCT_F_MODE_MSB     18
`define TDCT_F_MODE_LSB     16
`define TDCT_F_RADIX        19
`define TDCT_F_OUT          20
`define TDCT_F_HALT         21
`define TDCT_F_RUN          22
`define TDCT_F_LEVEL        0

// ------------------------------------------------------------
// Reset values and count constants
// ------------------------------------------------------------
`define TDCT_RST_COUNT      16'h0000
`define TDCT_RST_OUT        1'b0
`define TDCT_RST_HALT       1'b1
`define TDCT_RST_RDATA      32'h0000_0000
`define TDCT_TERMINAL       16'h0001
`define TDCT_BIN_FULL_HALF  16'h8000
`define TDCT_BCD_FULL_HALF  16'h5000
`define TDCT_MODE_LAST      3'h5

`endif

//--- src/tdct_pkg.sv
package tdct_pkg;

  // ------------------------------------------------------------
  // Modes and radix
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    terminal_toggle_mode,
    gated_single_pulse_mode,
    periodic_pulse_mode,
    half_duty_wave_mode,
    software_strobe_mode,
    gate_started_strobe_mode
  } tdct_mode_t;

  typedef enum logic {
    pure_binary_radix,
    decade_radix
  } tdct_radix_t;

  // ------------------------------------------------------------
  // Register port request
  // ------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } tdct_bus_req_t;

  // ------------------------------------------------------------
  // State of one counter
  // ------------------------------------------------------------
  typedef struct packed {
    tdct_mode_t  mode;
    tdct_radix_t count_radix_select;
    logic [15:0] count;
    logic [15:0] reload;
    logic        out;
    logic        run;
    logic        halted;
    logic        strobe_low;
    logic [1:0]  clk_sync;
    logic        clk_prev;
    logic [1:0]  gate_sync;
    logic        gate_prev;
  } tdct_chan_t;

endpackage

//--- verif/tdct_far_side.sv
`timescale 1ns/1ps
`default_nettype none

// Pin clocks and gates as the outside world drives them
module tdct_far_side (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_b,
  // Bench control
  input  wire logic       i_run,
  input  wire logic [2:0] i_gate_req,
  // Pins toward the block
  output logic      [2:0] o_cnt_clk,
  output logic      [2:0] o_cnt_gate
);
  logic [2:0] div;

  // Pin clock of 8 ref periods; it stands low while idle so no stray tick slips in
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      div        <= 3'h0;
      o_cnt_gate <= 3'h0;
    end
    else
    begin
      div        <= i_run ? div + 3'h1 : 3'h0;
      o_cnt_gate <= i_gate_req;
    end
  end

  assign o_cnt_clk = {3{div[2]}};
endmodule

`default_nettype wire

//--- verif/tdct_checker.sv
`timescale 1ns/1ps
`default_nettype none

module tdct_checker #(
  parameter int unsigned NUM_CNT = 3
) (
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_b,
  input  wire logic                    i_ce,
  // Register port
  input  wire tdct_pkg::tdct_bus_req_t i_bus,
  input  wire logic [31:0]             o_rdata,
  // Counter pins
  input  wire logic [NUM_CNT-1:0]      i_cnt_clk,
  input  wire logic [NUM_CNT-1:0]      i_cnt_gate,
  input  wire logic [NUM_CNT-1:0]      o_cnt_out
);
  logic [NUM_CNT-1:0] clk_d;
  logic [NUM_CNT-1:0] gate_d;
  logic [4:0]         hist;
  logic               setup_wr;
  logic               stop_wr;

  // Recent causes; the pin synchronisers delay their effect by a few cycles
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      clk_d  <= '0;
      gate_d <= '0;
      hist   <= 5'h00;
    end
    else
    begin
      clk_d  <= i_cnt_clk;
      gate_d <= i_cnt_gate;
      hist   <= {hist[3:0], i_bus.wr | (i_cnt_clk != clk_d) | (i_cnt_gate != gate_d)};
    end
  end

  // Accepted writes to a mapped counter
  assign setup_wr = i_ce && i_bus.wr && i_bus.addr[1:0] == 2'h0 && i_bus.addr[3:2] < NUM_CNT;
  assign stop_wr  = i_ce && i_bus.wr && i_bus.addr[1:0] == 2'h3 && i_bus.addr[3:2] < NUM_CNT;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_toggle_starts_low: assert property (
    setup_wr && i_bus.wdata[18:16] == 3'h0 |=> o_cnt_out[$past(i_bus.addr[3:2])] == 1'b0)
    else $error("toggle mode output not low after setup");
  a_other_modes_high: assert property (
    setup_wr && i_bus.wdata[18:16] inside {[3'h1:3'h5]}
    |=> o_cnt_out[$past(i_bus.addr[3:2])] == 1'b1)
    else $error("output not high after setup");
  a_stop_sets_level: assert property (
    stop_wr |=> o_cnt_out[$past(i_bus.addr[3:2])] == $past(i_bus.wdata[0]))
    else $error("stop level not driven");
  a_halt_freezes_out: assert property (
    (i_bus.wr && i_bus.addr == 4'h3) ##1 (!i_bus.wr) [*8] |-> $stable(o_cnt_out[0]))
    else $error("halted output moved");
  a_rdata_idle_zero: assert property (
    i_ce && !i_bus.rd |=> o_rdata == 32'h0000_0000)
    else $error("read data without read");
  a_unmapped_reads_zero: assert property (
    i_ce && i_bus.rd && i_bus.addr[3:2] >= NUM_CNT |=> o_rdata == 32'h0000_0000)
    else $error("unmapped counter read not zero");
  a_stop_reads_zero: assert property (
    i_ce && i_bus.rd && i_bus.addr[1:0] == 2'h3 |=> o_rdata == 32'h0000_0000)
    else $error("stop register read not zero");
  a_out_has_cause: assert property (
    o_cnt_out != $past(o_cnt_out) |-> |hist)
    else $error("output changed without write or pin event");
endmodule

`default_nettype wire

//--- verif/tdct_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tdct_tb_top;
  localparam int unsigned NUM_CNT = 3;
  // Radix table: {bcd, loaded count, count after one tick}
  localparam logic [32:0] RADIX_TBL [4] = '{{1'b0, 16'h0010, 16'h000F},
    {1'b1, 16'h0010, 16'h0009}, {1'b0, 16'h0000, 16'hFFFF}, {1'b1, 16'h0000, 16'h9999}};

  logic                    i_ref_clk;
  logic                    i_rst_b;
  logic                    i_ce;
  logic                    run;
  tdct_pkg::tdct_bus_req_t i_bus;
  logic [31:0]             o_rdata;
  logic [31:0]             rd_val;
  logic [2:0]              cnt_clk;
  logic [2:0]              cnt_gate;
  logic [2:0]              gate_req;
  logic [2:0]              cnt_out;
  int                      miscompares;
  int                      total_checks;

  tdct_top #(.NUM_CNT(NUM_CNT)) i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_cnt_clk(cnt_clk), .i_cnt_gate(cnt_gate),
    .o_cnt_out(cnt_out));
  tdct_far_side i_far (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_run(run),
    .i_gate_req(gate_req), .o_cnt_clk(cnt_clk), .o_cnt_gate(cnt_gate));

  // 250 MHz reference clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_ref_clk);
    i_bus <= '0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_ref_clk);
    i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge i_ref_clk);
    i_bus <= '0;
    #1;
    rd_val = o_rdata;
  endtask

  function automatic logic [31:0] setw(input logic [2:0] m, input logic bcd, input logic [15:0] c);
    return {12'h000, bcd, m, c};
  endfunction

  // Exactly n pin ticks, then the pin clock stands still so setup is never raced
  task automatic ticks(input int n);
    run <= 1'b1;
    repeat (n) @(posedge cnt_clk[0]);
    repeat (4) @(posedge i_ref_clk);
    run <= 1'b0;
    #1;
  endtask

  task automatic wait_lvl(input int ch, input logic v, output int n);
    n = 0;
    while (cnt_out[ch] !== v && n < 400)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
  endtask

  task automatic measure(input int ch, output int lo, output int per);
    int n;
    run <= 1'b1;
    wait_lvl(ch, 1'b1, n);
    wait_lvl(ch, 1'b0, n);
    wait_lvl(ch, 1'b1, lo);
    wait_lvl(ch, 1'b0, n);
    per = lo + n;
    run <= 1'b0;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic toggle_test;
    gate_req <= 3'h7;
    wr(4'h0, setw(3'h0, 1'b0, 16'h0003));
    check("toggle out", cnt_out[0], 1'b0);
    ticks(2);
    rd(4'h2);
    check("live count", rd_val, 32'h0000_0001);
    check("toggle out", cnt_out[0], 1'b0);
    ticks(1);
    check("toggle out", cnt_out[0], 1'b1);
    ticks(2);
    check("toggle out", cnt_out[0], 1'b1);
    gate_req <= 3'h0;
    wr(4'h0, setw(3'h0, 1'b0, 16'h0005));
    ticks(3);
    rd(4'h2);
    check("gated count", rd_val, 32'h0000_0005);
  endtask

  task automatic strobe_test;
    gate_req <= 3'h7;
    wr(4'h4, setw(3'h4, 1'b0, 16'h0009));
    check("strobe out", cnt_out[1], 1'b1);
    wr(4'h5, 32'h0000_0002);
    rd(4'h4);
    check("mode kept", rd_val[19:0], 20'h4_0002);
    ticks(2);
    check("strobe out", cnt_out[1], 1'b0);
    ticks(1);
    check("strobe out", cnt_out[1], 1'b1);
  endtask

  task automatic wave_test;
    int lo;
    int per;
    wr(4'h8, setw(3'h2, 1'b0, 16'h0004));
    measure(2, lo, per);
    check("pulse low", lo, 8);
    check("pulse period", per, 32);
    wr(4'h8, setw(3'h3, 1'b0, 16'h0006));
    measure(2, lo, per);
    check("wave low", lo, 24);
    check("wave period", per, 48);
  endtask

  task automatic one_shot_test;
    gate_req <= 3'h0;
    wr(4'h0, setw(3'h1, 1'b0, 16'h0003));
    gate_req <= 3'h1;
    repeat (6) @(posedge i_ref_clk);
    check("shot out", cnt_out[0], 1'b0);
    ticks(2);
    check("shot out", cnt_out[0], 1'b0);
    ticks(1);
    check("shot out", cnt_out[0], 1'b1);
    gate_req <= 3'h0;
    wr(4'h0, setw(3'h5, 1'b0, 16'h0002));
    ticks(2);
    check("hw strobe idle", cnt_out[0], 1'b1);
    gate_req <= 3'h1;
    repeat (6) @(posedge i_ref_clk);
    gate_req <= 3'h0;
    repeat (6) @(posedge i_ref_clk);
    ticks(2);
    check("hw strobe out", cnt_out[0], 1'b0);
    ticks(1);
    check("hw strobe out", cnt_out[0], 1'b1);
  endtask

  task automatic stop_test;
    gate_req <= 3'h7;
    wr(4'h0, setw(3'h0, 1'b0, 16'h0002));
    check("toggle out", cnt_out[0], 1'b0);
    wr(4'h3, 32'h0000_0001);
    check("stop out", cnt_out[0], 1'b1);
    ticks(2);
    rd(4'h3);
    check("stop reg", rd_val, 32'h0000_0000);
    rd(4'h0);
    check("halted", {rd_val[21], rd_val[20]}, 2'h3);
    wr(4'h3, 32'h0000_0000);
    wr(4'h1, 32'h0000_0001);
    ticks(2);
    check("stop out", cnt_out[0], 1'b0);
  endtask

  task automatic radix_test;
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h8, setw(3'h0, RADIX_TBL[k][32], RADIX_TBL[k][31:16]));
      ticks(1);
      rd(4'hA);
      check("radix count", rd_val, {16'h0000, RADIX_TBL[k][15:0]});
    end
  endtask

  task automatic map_test;
    rd(4'hC);
    check("unmapped", rd_val, 32'h0000_0000);
    wr(4'h8, setw(3'h6, 1'b0, 16'h1234));
    rd(4'h8);
    check("bad mode", rd_val[19:0], 20'h8_0000);
    rd(4'h4);
    check("own mode", rd_val[18:16], 3'h4);
    // Clock enable low must swallow pin ticks; counting resumes afterwards
    i_ce <= 1'b0;
    ticks(2);
    i_ce <= 1'b1;
    rd(4'hA);
    check("frozen count", rd_val, 32'h0000_9999);
    ticks(1);
    rd(4'hA);
    check("resumed count", rd_val, 32'h0000_9998);
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_bus = '0;
    run = 1'b0;
    gate_req = 3'h0;
    miscompares = 0;
    total_checks = 0;
    repeat (16) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    toggle_test();
    strobe_test();
    wave_test();
    one_shot_test();
    stop_test();
    radix_test();
    map_test();
    wrap_up();
  end

  // Watchdog: the tests need well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    miscompares++;
    wrap_up();
  end
endmodule

bind tdct_top tdct_checker #(.NUM_CNT(NUM_CNT)) u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
  .i_ce(i_ce), .i_bus(i_bus), .o_rdata(o_rdata), .i_cnt_clk(i_cnt_clk),
  .i_cnt_gate(i_cnt_gate), .o_cnt_out(o_cnt_out));

`default_nettype wire
